// *** rtl/temp_sensor_i2c_slave_regs.sv ***
// Summary of operation
// - fault queue code sets 1,2,4,6 faults
// - polarity bit zero gives active-low alert
// - mode bit selects comparator or interrupt
// - shutdown stops continuous conversions, one-shot starts and bus keep working
// - limits are 16-bit two's complement
// - limit reads send upper byte first
// - limits reset to 75 and 80 degrees
// - address is 1001 plus three pins
// - address pins sampled continuously
// - data line idle timeout abandons transfer
// - start then seven address bits, direction
// - acknowledge own address, else stay idle
// - nine clocks per byte, change low
// - direction zero writes, one reads
// - direction fixed until new start
// - first written byte loads the pointer
// - config write takes one data byte
// - limit write takes two data bytes
// - pointer low bits select register, resets zero
// - comparator asserts at limit, clears below hyst
// - interrupt clears on any register read
// - one-shot pointer write starts one conversion
`timescale 1ns/100ps
module temp_sensor_i2c_slave_regs #(
    parameter int TIMEOUT_CYCLES = temp_sensor_pkg::TIMEOUT_CYCLES
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    // serial bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // address select pins
    input wire logic ADDR_SELECT_BIT2_IN,
    input wire logic ADDR_SELECT_BIT1_IN,
    input wire logic ADDR_SELECT_BIT0_IN,
    // converter side
    input wire logic CONV_DONE_IN,
    input wire logic [15:0] TEMP_VALUE_IN,
    output logic CONV_RUN_OUT,
    output logic ONESHOT_START_OUT,
    // alert
    output logic OVERTEMP_ALERT_OUTPUT_OUT
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK
    } bus_state_t;

    // ------------------------------------------------------------
    // synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q;
    logic [2:0] addr_s1_q, addr_s2_q;
    logic scl_prev_q, sda_prev_q;
    logic scl_rise, scl_fall, start_det, stop_det, sda_edge;
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            addr_s1_q <= 3'h0;
            addr_s2_q <= 3'h0;
        end else begin
            scl_sync_q <= {scl_sync_q[0], SCL_IN};
            sda_sync_q <= {sda_sync_q[0], SDA_IN};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            // pins re-sampled every cycle, no latch at power-up
            addr_s1_q <= {ADDR_SELECT_BIT2_IN, ADDR_SELECT_BIT1_IN,
                ADDR_SELECT_BIT0_IN};
            addr_s2_q <= addr_s1_q;
        end
    end
    assign scl_rise = scl_sync_q[1] && !scl_prev_q;
    assign scl_fall = !scl_sync_q[1] && scl_prev_q;
    assign sda_edge = sda_sync_q[1] != sda_prev_q;
    assign start_det = scl_sync_q[1] && scl_prev_q && sda_edge
        && !sda_sync_q[1];
    assign stop_det = scl_sync_q[1] && scl_prev_q && sda_edge
        && sda_sync_q[1];

    // ------------------------------------------------------------
    // bus engine and registers
    // ------------------------------------------------------------
    bus_state_t state_q, state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic rnw_q, rnw_d;
    logic [1:0] byte_cnt_q, byte_cnt_d;
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] cfg_q, cfg_d;
    logic [15:0] hyst_q, hyst_d;
    logic [15:0] otemp_q, otemp_d;
    logic [7:0] hold_q, hold_d;
    logic sda_low_q, sda_low_d;
    logic [31:0] idle_cnt_q, idle_cnt_d;
    logic oneshot_d, read_done_d;
    logic [15:0] rd_word;
    logic timeout;

    always_comb begin
        unique case (ptr_q[2:0])
            temp_sensor_pkg::PTR_TEMP: rd_word = TEMP_VALUE_IN;
            temp_sensor_pkg::PTR_CONFIG: rd_word = {cfg_q, cfg_q};
            temp_sensor_pkg::PTR_HYST: rd_word = hyst_q;
            temp_sensor_pkg::PTR_OVERTEMP: rd_word = otemp_q;
            default: rd_word = 16'h0000;
        endcase
    end

    assign timeout = idle_cnt_q >= 32'(TIMEOUT_CYCLES);

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        rnw_d = rnw_q;
        byte_cnt_d = byte_cnt_q;
        ptr_d = ptr_q;
        cfg_d = cfg_q;
        hyst_d = hyst_q;
        otemp_d = otemp_q;
        hold_d = hold_q;
        sda_low_d = sda_low_q;
        oneshot_d = 1'b0;
        read_done_d = 1'b0;
        idle_cnt_d = (sda_edge || state_q == ST_IDLE) ? 32'h0
            : idle_cnt_q + 32'h1;
        if (start_det) begin
            // repeated start also re-reads the direction bit
            state_d = ST_ADDR;
            bit_cnt_d = 4'h0;
            sda_low_d = 1'b0;
            byte_cnt_d = 2'h0;
        end else if (stop_det || timeout) begin
            state_d = ST_IDLE;
            sda_low_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: sda_low_d = 1'b0;
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_sync_q[1]};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_d = 4'h0;
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == {temp_sensor_pkg::ADDR_FIXED_HI,
                                    addr_s2_q}) begin
                                rnw_d = shift_q[0];
                                sda_low_d = 1'b1;
                                state_d = ST_ACK;
                            end else begin
                                state_d = ST_IDLE;
                            end
                        end else begin
                            sda_low_d = 1'b1;
                            state_d = ST_ACK;
                            if (byte_cnt_q == 2'h0) begin
                                ptr_d = shift_q;
                                oneshot_d = shift_q[2:0] ==
                                    temp_sensor_pkg::PTR_ONESHOT;
                            end else if (ptr_q[2:0] ==
                                    temp_sensor_pkg::PTR_CONFIG) begin
                                cfg_d = shift_q;
                            end else if (byte_cnt_q == 2'h1) begin
                                hold_d = shift_q;
                            end else if (byte_cnt_q == 2'h2 && ptr_q[2:0] ==
                                    temp_sensor_pkg::PTR_HYST) begin
                                hyst_d = {hold_q, shift_q};
                            end else if (byte_cnt_q == 2'h2 && ptr_q[2:0] ==
                                    temp_sensor_pkg::PTR_OVERTEMP) begin
                                otemp_d = {hold_q, shift_q};
                            end
                            if (byte_cnt_q != 2'h3) begin
                                byte_cnt_d = byte_cnt_q + 2'h1;
                            end
                        end
                    end
                end
                ST_ACK, ST_RACK: begin
                    if (state_q == ST_RACK && scl_rise && sda_sync_q[1]) begin
                        // master nack ends the read
                        state_d = ST_IDLE;
                    end else if (scl_fall) begin
                        // ninth clock done; release or present next byte
                        if (rnw_q) begin
                            shift_d = (byte_cnt_q == 2'h0) ? rd_word[15:8]
                                : rd_word[7:0];
                            sda_low_d = !shift_d[7];
                            shift_d = {shift_d[6:0], 1'b0};
                            bit_cnt_d = 4'h1;
                            byte_cnt_d = byte_cnt_q ^ 2'h1;
                            // only the address ack opens a new read
                            read_done_d = state_q == ST_ACK;
                            state_d = ST_READ;
                        end else begin
                            sda_low_d = 1'b0;
                            state_d = ST_WRITE;
                        end
                    end
                end
                ST_READ: if (scl_fall) begin
                    if (bit_cnt_q == 4'h8) begin
                        sda_low_d = 1'b0;
                        state_d = ST_RACK;
                    end else begin
                        sda_low_d = !shift_q[7];
                        shift_d = {shift_q[6:0], 1'b0};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            rnw_q <= 1'b0;
            byte_cnt_q <= 2'h0;
            ptr_q <= temp_sensor_pkg::PTR_RESET;
            cfg_q <= temp_sensor_pkg::CONFIG_RESET;
            hyst_q <= temp_sensor_pkg::HYST_RESET;
            otemp_q <= temp_sensor_pkg::OVERTEMP_RESET;
            hold_q <= 8'h00;
            sda_low_q <= 1'b0;
            idle_cnt_q <= 32'h0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            rnw_q <= rnw_d;
            byte_cnt_q <= byte_cnt_d;
            ptr_q <= ptr_d;
            cfg_q <= cfg_d;
            hyst_q <= hyst_d;
            otemp_q <= otemp_d;
            hold_q <= hold_d;
            sda_low_q <= sda_low_d;
            idle_cnt_q <= idle_cnt_d;
        end
    end
    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = sda_low_q;

    // ------------------------------------------------------------
    // fault queue and alert
    // ------------------------------------------------------------
    logic [2:0] fault_cnt_q, fault_cnt_d, queue_need;
    logic alert_q, alert_d, os_start_q;
    logic fault, below_hyst;
    always_comb begin
        unique case (cfg_q[temp_sensor_pkg::CFG_QUEUE_LO +: 2])
            2'h0: queue_need = temp_sensor_pkg::QUEUE_1;
            2'h1: queue_need = temp_sensor_pkg::QUEUE_2;
            2'h2: queue_need = temp_sensor_pkg::QUEUE_4;
            2'h3: queue_need = temp_sensor_pkg::QUEUE_6;
        endcase
    end
    assign fault = $signed(TEMP_VALUE_IN) >= $signed(otemp_q);
    assign below_hyst = $signed(TEMP_VALUE_IN) < $signed(hyst_q);
    always_comb begin
        fault_cnt_d = fault_cnt_q;
        alert_d = alert_q;
        if (CONV_DONE_IN) begin
            if (!fault) begin
                fault_cnt_d = 3'h0;
            end else if (fault_cnt_q != queue_need) begin
                fault_cnt_d = fault_cnt_q + 3'h1;
            end
        end
        if (cfg_q[temp_sensor_pkg::CFG_INT_MODE]) begin
            // rising into the queue depth only: one event per crossing
            if (read_done_d) begin
                alert_d = 1'b0;
            end
            if (CONV_DONE_IN && fault && fault_cnt_d == queue_need
                    && fault_cnt_q != queue_need) begin
                alert_d = 1'b1;
            end
        end else if (CONV_DONE_IN) begin
            if (fault && fault_cnt_d == queue_need) begin
                alert_d = 1'b1;
            end else if (below_hyst) begin
                alert_d = 1'b0;
            end
        end
    end
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            fault_cnt_q <= 3'h0;
            alert_q <= 1'b0;
            os_start_q <= 1'b0;
        end else begin
            fault_cnt_q <= fault_cnt_d;
            alert_q <= alert_d;
            os_start_q <= oneshot_d && cfg_q[temp_sensor_pkg::CFG_ONESHOT];
        end
    end
    assign OVERTEMP_ALERT_OUTPUT_OUT = alert_q
        ^ !cfg_q[temp_sensor_pkg::CFG_POLARITY];
    // one-shot mode idles the converter between triggers
    assign CONV_RUN_OUT = !cfg_q[temp_sensor_pkg::CFG_SHUTDOWN]
        && !cfg_q[temp_sensor_pkg::CFG_ONESHOT];
    assign ONESHOT_START_OUT = os_start_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_POLARITY: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) OVERTEMP_ALERT_OUTPUT_OUT ==
        (alert_q == cfg_q[temp_sensor_pkg::CFG_POLARITY]))
        else $error("alert polarity wrong");
    AST_SHUTDOWN: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) cfg_q[temp_sensor_pkg::CFG_SHUTDOWN] |-> !CONV_RUN_OUT)
        else $error("converter runs in shutdown");
    AST_STOP_IDLE: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) stop_det |=> state_q == ST_IDLE && !SDA_OE_OUT)
        else $error("stop did not release bus");
    AST_NOMATCH: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) state_q == ST_IDLE && !start_det |=> !SDA_OE_OUT)
        else $error("idle device drives data");
    AST_ACK: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) state_q == ST_ACK |-> SDA_OE_OUT)
        else $error("ack slot not driven low");
    AST_FAULT_CLR: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) CONV_DONE_IN && !fault |=> fault_cnt_q == 3'h0)
        else $error("fault counter not cleared");
    AST_CMP_CLR: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) !cfg_q[temp_sensor_pkg::CFG_INT_MODE] && CONV_DONE_IN
        && !fault && below_hyst |=> !alert_q)
        else $error("comparator alert not cleared");
    AST_INT_CLR: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) cfg_q[temp_sensor_pkg::CFG_INT_MODE] && read_done_d
        && !CONV_DONE_IN |=> !alert_q)
        else $error("read did not clear alert");
    AST_QUEUE: assert property (@(posedge CORE_CLK_IN) disable iff
        (!RST_N_IN) $rose(alert_q) |-> fault_cnt_q == queue_need)
        else $error("alert before queue depth");
    COV_READ: cover property (@(posedge CORE_CLK_IN) state_q == ST_READ);
    COV_WRITE: cover property (@(posedge CORE_CLK_IN)
        state_q == ST_WRITE && byte_cnt_q == 2'h2);
    COV_ALERT: cover property (@(posedge CORE_CLK_IN) $rose(alert_q));
    COV_ONESHOT: cover property (@(posedge CORE_CLK_IN) ONESHOT_START_OUT);
endmodule // temp_sensor_i2c_slave_regs

// *** rtl/temp_sensor_pkg.sv ***
package temp_sensor_pkg;
    // ------------------------------------------------------------
    // bus address and pointer codes
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FIXED_HI = 4'h9;
    localparam logic [2:0] PTR_TEMP = 3'h0;
    localparam logic [2:0] PTR_CONFIG = 3'h1;
    localparam logic [2:0] PTR_HYST = 3'h2;
    localparam logic [2:0] PTR_OVERTEMP = 3'h3;
    localparam logic [2:0] PTR_ONESHOT = 3'h4;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // ------------------------------------------------------------
    // configuration fields and reset values
    // ------------------------------------------------------------
    localparam int CFG_SHUTDOWN = 0;
    localparam int CFG_INT_MODE = 1;
    localparam int CFG_POLARITY = 2;
    localparam int CFG_QUEUE_LO = 3;
    localparam int CFG_ONESHOT = 5;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [15:0] HYST_RESET = 16'h4B00;
    localparam logic [15:0] OVERTEMP_RESET = 16'h5000;
    localparam logic [2:0] QUEUE_1 = 3'h1;
    localparam logic [2:0] QUEUE_2 = 3'h2;
    localparam logic [2:0] QUEUE_4 = 3'h4;
    localparam logic [2:0] QUEUE_6 = 3'h6;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
endpackage

// *** testbench/i2c_master_model.sv ***
`timescale 1ns/100ps
module i2c_master_model (
    // device pull-down request
    input wire logic sda_oe_in,
    // resolved bus wires
    output logic scl_out,
    output logic sda_out
);
    logic hold_low = 1'b0;
    real q = 31.25;
    // stretches the low phase to act as a slow master
    int slow = 1;
    // ------------------------------------------------------------
    // open-drain wire with pull-up, clock idles high
    // ------------------------------------------------------------
    assign sda_out = !(hold_low || sda_oe_in);
    initial scl_out = 1'b1;
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic start_cond();
        hold_low = 1'b0;
        #(q);
        scl_out = 1'b1;
        #(q);
        hold_low = 1'b1;
        #(q);
        scl_out = 1'b0;
        #(q);
    endtask
    task automatic bit_slot(input logic b, output logic r);
        hold_low = !b;
        #(q * slow);
        scl_out = 1'b1;
        #(q);
        r = sda_out;
        #(q);
        scl_out = 1'b0;
        #(q * slow);
    endtask
    task automatic stop_cond();
        hold_low = 1'b1;
        #(q);
        scl_out = 1'b1;
        #(q);
        hold_low = 1'b0;
        #(2 * q);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
        bit_slot(1'b1, r);
        ack = !r;
    endtask
    // most significant bit first; released slot after last byte ends it
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, r);
            d[i] = r;
        end
        bit_slot(last, r);
    endtask
    task automatic idle(input int n);
        #(4 * q * n);
    endtask
endmodule // i2c_master_model

// *** testbench/test_temp_sensor_i2c_slave_regs.sv ***
`timescale 1ns/100ps
module test_temp_sensor_i2c_slave_regs;
    localparam int TMO = 2000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic done = 1'b0;
    logic [15:0] temp = 16'h0000;
    logic [2:0] pins = 3'h0;
    logic [2:0] dev = 3'h0;
    wire scl;
    wire sda;
    logic sda_o, sda_oe, run, shot, alert;
    int errors = 0;
    int compares = 0;
    int shots = 0;
    int exp_shots = 0;
    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    logic [7:0] cfg_m = 8'h00;
    logic [15:0] hyst_m = 16'h4B00;
    logic [15:0] ot_m = 16'h5000;
    logic [2:0] ptr_m = 3'h0;
    int cnt_m = 0;
    logic act_m = 1'b0;
    int depth[4] = '{1, 2, 4, 6};

    i2c_master_model mst (.sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    temp_sensor_i2c_slave_regs #(.TIMEOUT_CYCLES(TMO)) uut (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
        .ADDR_SELECT_BIT2_IN(pins[2]), .ADDR_SELECT_BIT1_IN(pins[1]),
        .ADDR_SELECT_BIT0_IN(pins[0]), .CONV_DONE_IN(done),
        .TEMP_VALUE_IN(temp), .CONV_RUN_OUT(run),
        .ONESHOT_START_OUT(shot), .OVERTEMP_ALERT_OUTPUT_OUT(alert));

    initial begin
        forever #5 clk = ~clk;
    end
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clk) begin
        if (shot === 1'b1) shots++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [15:0] reg_m();
        return ptr_m == 3'h1 ? {8'h00, cfg_m} : ptr_m == 3'h2 ? hyst_m :
               ptr_m == 3'h3 ? ot_m : 16'h0000;
    endfunction
    task automatic pin_chk();
        #1;
        check(16'(alert), 16'(cfg_m[2] ? act_m : !act_m), "alert");
        check(16'(run), 16'(!(cfg_m[0] || cfg_m[5])), "run");
        check(16'(sda_o), 16'h0000, "data drive level");
    endtask
    // ------------------------------------------------------------
    // bus transfers
    // ------------------------------------------------------------
    task automatic open_xfer(input logic rw, input logic hit);
        logic a;
        #2;
        mst.start_cond();
        mst.send_byte({4'h9, dev, rw}, a);
        check(16'(a), 16'(hit), "address ack");
    endtask
    task automatic wr(input logic [7:0] p, input int n, input logic [15:0] v);
        logic a;
        open_xfer(1'b0, 1'b1);
        mst.send_byte(p, a);
        if (n > 1) mst.send_byte(v[15:8], a);
        if (n > 0) mst.send_byte(v[7:0], a);
        check(16'(a), 16'h0001, "write ack");
        mst.stop_cond();
        ptr_m = p[2:0];
        if (ptr_m == 3'h4 && cfg_m[5]) exp_shots++;
        if (n == 1 && ptr_m == 3'h1) cfg_m = v[7:0];
        if (n == 2 && ptr_m == 3'h2) hyst_m = v;
        if (n == 2 && ptr_m == 3'h3) ot_m = v;
    endtask
    task automatic rd(input int n, input string what);
        logic [7:0] b1, b2;
        logic [15:0] got;
        open_xfer(1'b1, 1'b1);
        mst.get_byte(n == 1, b1);
        got = {8'h00, b1};
        if (n == 2) begin
            mst.get_byte(1'b1, b2);
            got = {b1, b2};
        end
        mst.stop_cond();
        if (cfg_m[1]) act_m = 1'b0;
        check(got, reg_m(), what);
    endtask
    task automatic conv(input logic [15:0] t);
        @(posedge clk);
        temp <= t;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (4) @(posedge clk);
        cnt_m = $signed(t) >= $signed(ot_m) ? cnt_m + 1 : 0;
        if (!cfg_m[1] && cnt_m >= depth[cfg_m[4:3]]) act_m = 1'b1;
        else if (!cfg_m[1] && $signed(t) < $signed(hyst_m)) act_m = 1'b0;
        if (cfg_m[1] && cnt_m == depth[cfg_m[4:3]]) act_m = 1'b1;
        pin_chk();
    endtask

    initial begin
        logic a;
        void'($urandom(32'h9A1F));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        pin_chk();
        for (int p = 3; p >= 1; p--) begin
            wr(8'(p), 0, 16'h0000);
            rd(p == 1 ? 1 : 2, "reset value");
        end
        rd(1, "pointer kept");
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            pins <= 3'(k);
            mst.slow = 1 + k % 2;
            repeat (4) @(posedge clk);
            dev = 3'(k);
            wr(8'h02, 2, 16'($urandom_range(32'h3FF0, 32'h1000)));
            rd(2, "hysteresis");
            dev = 3'(k) ^ 3'h5;
            open_xfer(1'b0, 1'b0);
            mst.stop_cond();
            dev = 3'(k);
        end
        mst.slow = 1;
        wr(8'h03, 2, hyst_m + 16'h0800);
        rd(2, "overtemp");
        $display("test addressing and limits done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h01, 1, 16'({c[1:0], c[0], c[2], 1'b0}));
            rd(1, "config");
            pin_chk();
            for (int i = 1; i < depth[c[1:0]]; i++) conv(ot_m);
            conv(ot_m - 16'h0010);
            for (int i = 0; i < depth[c[1:0]]; i++) begin
                conv(ot_m + 16'($urandom_range(255)));
            end
            conv(hyst_m - 16'h0010);
            rd(1, "config again");
            pin_chk();
            conv(16'h8000 | 16'($urandom_range(32'h7FFF)));
        end
        $display("test alert modes done");
        wr(8'h01, 1, 16'h0001);
        pin_chk();
        wr(8'h01, 1, 16'h0000);
        pin_chk();
        wr(8'h04, 0, 16'h0000);
        wr(8'h01, 1, 16'h0020);
        wr(8'h04, 1, 16'h00A5);
        pin_chk();
        wr(8'h01, 0, 16'h0000);
        rd(1, "config after one-shot");
        check(16'(shots), 16'(exp_shots), "one-shot pulses");
        wr(8'h01, 1, 16'h0000);
        $display("test shutdown and one-shot done");
        wr(8'h02, 0, 16'h0000);
        #2;
        mst.start_cond();
        mst.send_byte({4'h9, dev, 1'b1}, a);
        mst.bit_slot(1'b1, a);
        mst.idle(1);
        check(16'(sda_oe), 16'(!hyst_m[14]), "data held");
        mst.idle(TMO / 10);
        check(16'(sda_oe), 16'h0000, "timeout release");
        mst.stop_cond();
        rd(2, "after timeout");
        $display("test timeout done");
        wrap_up();
    end
    initial begin
        #600000;
        errors++;
        $display("wrong value at %0t: run did not finish", $time);
        wrap_up();
    end
endmodule // test_temp_sensor_i2c_slave_regs
